// ===== pkg/rtccfg_pkg.sv
package rtccfg_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and time
	localparam int unsigned CLK_HZ = 20000000;
	localparam int unsigned TICK_PERIOD_S = 1;
	localparam int unsigned SEC_CYCLES = TICK_PERIOD_S * CLK_HZ;
	localparam int unsigned SQW_HZ_1 = 4098;
	localparam int unsigned SQW_HZ_2 = 8192;
	localparam int unsigned SQW_HZ_3 = 32768;
	localparam int unsigned SQW_HALF_0 = CLK_HZ / 2;
	localparam int unsigned SQW_HALF_1 = CLK_HZ / (2 * SQW_HZ_1);
	localparam int unsigned SQW_HALF_2 = CLK_HZ / (2 * SQW_HZ_2);
	localparam int unsigned SQW_HALF_3 = CLK_HZ / (2 * SQW_HZ_3);
	localparam logic [15:0] REF_DIV_0 = 16'h0001;
	localparam logic [15:0] REF_DIV_1 = 16'h0032;
	localparam logic [15:0] REF_DIV_2 = 16'h003C;
	localparam logic [15:0] REF_DIV_3 = 16'h8000;

	////////////////////////////////////////////////////////////////////////
	// Register offsets
	localparam logic [7:0] ADDR_CFG1 = 8'h00;
	localparam logic [7:0] ADDR_CFG2 = 8'h01;
	localparam logic [7:0] ADDR_SEC = 8'h06;
	localparam logic [7:0] ADDR_YEAR = 8'h0C;
	localparam logic [7:0] ADDR_A1_SEC = 8'h0D;
	localparam logic [7:0] ADDR_A1_MIN = 8'h0E;
	localparam logic [7:0] ADDR_A1_HRS = 8'h0F;
	localparam logic [7:0] ADDR_A1_DD = 8'h10;
	localparam logic [7:0] ADDR_A1_MON = 8'h11;
	localparam logic [7:0] ADDR_A1_YEAR = 8'h12;
	localparam logic [7:0] ADDR_A2_MIN = 8'h13;
	localparam logic [7:0] ADDR_A2_HRS = 8'h14;
	localparam logic [7:0] ADDR_A2_DD = 8'h15;
	localparam logic [7:0] ADDR_TMR_CNT = 8'h16;
	localparam logic [7:0] ADDR_TMR_INIT = 8'h17;
	localparam logic [7:0] ADDR_SYNC = 8'h58;
	localparam int unsigned NREG = 24;

	////////////////////////////////////////////////////////////////////////
	// Field positions, reset values, masks
	localparam int unsigned CFG1_EXT_REF = 7;
	localparam int unsigned CFG1_PIN_FN = 6;
	localparam int unsigned CFG1_REF_SEL = 4;
	localparam int unsigned CFG1_OSC_DIS = 3;
	localparam int unsigned CFG1_SQW_SEL = 1;
	localparam int unsigned CFG1_SOFT_RST = 0;
	localparam int unsigned CFG2_RETEN = 6;
	localparam int unsigned CFG2_TMO_EN = 3;
	localparam int unsigned CFG2_RD_RUN = 2;
	localparam int unsigned CFG2_LOAD = 1;
	localparam int unsigned ALM_MASK = 7;
	localparam int unsigned ALM_DAY_SEL = 6;
	localparam logic [7:0] CFG1_RST = 8'h0E;
	localparam logic [7:0] CFG2_RST = 8'h0C;
	localparam logic [7:0] CFG2_MASK = 8'h4E;

	////////////////////////////////////////////////////////////////////////
	// Calendar limits in BCD
	localparam logic [7:0] BCD_MS_LAST = 8'h59;
	localparam logic [7:0] BCD_HR_LAST = 8'h23;
	localparam logic [7:0] BCD_DAY_LAST = 8'h07;
	localparam logic [7:0] BCD_MON_LAST = 8'h12;
	localparam logic [7:0] BCD_YEAR_LAST = 8'h99;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
	} rtccfg_wr_t;

endpackage

// ===== rtl/rtccfg_top.sv
`timescale 1ns/10ps
// Behaviour
// - Oscillator runs while disable bit and retention bit are both 0, stops while either is 1.
// - Reference field picks external reference rate: 1 Hz, 50, 60, 32768.
// - Square-wave field picks output rate: 1 Hz, 4.098k, 8.192k, 32.768k.
// - Pin-function bit: 0 square wave on shared pin, 1 interrupt.
// - Soft reset bit 1 holds digital counting logic in reset; resets 0.
// - Retention bit 1 enters data-retention mode, 0 normal operation.
// - Read-select 0: time registers read back last written values.
// - Read-select 1, the default: time registers read running time.
// - Load bit rising edge copies time registers into counting chain.
// - Pin-function and reference-enable bits route both pins per four modes.
module rtccfg_top #(
	parameter int unsigned SEC_CYCLES = rtccfg_pkg::SEC_CYCLES,
	parameter int unsigned SQW_SLOW_HALF = rtccfg_pkg::SQW_HALF_0,
	// Arbitrary bus address
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// System
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial bus, link clock domain
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_drive_n,
	// Shared pins
	input wire logic first_pin_in,
	output logic first_pin_out,
	output logic first_pin_drive_n,
	output logic second_pin_out,
	output logic second_pin_drive_n,
	// Events and count from neighbouring blocks
	input wire logic alarm_one_event,
	input wire logic alarm_two_event,
	input wire logic timer_event,
	input wire logic [7:0] timer_count_value,
	// Status
	output logic oscillator_run,
	output logic retention_mode,
	output logic bus_timeout_enable,
	output logic alarm_one_match,
	output logic alarm_two_match
);

	typedef enum logic [2:0] {L_IDLE, L_ADDR, L_REG, L_WRITE, L_READ}
		rtccfg_lstate_t;

	function automatic logic [7:0] bcd_next(input logic [7:0] v,
		input logic [7:0] last, input logic [7:0] first);
		if (v == last)
			return first;
		if (v[3:0] == 4'h9)
			return {v[7:4] + 4'h1, 4'h0};
		return v + 8'h01;
	endfunction

	function automatic logic [7:0] wr_mask(input logic [7:0] a);
		case (a)
		rtccfg_pkg::ADDR_CFG1: return 8'hFF;
		rtccfg_pkg::ADDR_CFG2: return rtccfg_pkg::CFG2_MASK;
		8'h06, 8'h07: return 8'h7F;
		8'h08, 8'h0A: return 8'h3F;
		8'h09: return 8'h07;
		8'h0B: return 8'h9F;
		rtccfg_pkg::ADDR_A1_HRS, rtccfg_pkg::ADDR_A2_HRS: return 8'hBF;
		rtccfg_pkg::ADDR_A1_MON: return 8'hDF;
		8'h0C, 8'h0D, 8'h0E, 8'h10, 8'h12, 8'h13, 8'h15,
		rtccfg_pkg::ADDR_TMR_INIT: return 8'hFF;
		default: return 8'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Link domain: start marker, bit sampling, byte framing
	logic link_hold;
	logic start_tog, next_start_tog;
	logic master_nack, ack_s1, ack_s2;
	logic [7:0] rx;
	rtccfg_lstate_t lstate, next_lstate;
	logic [3:0] bit_cnt, next_bit_cnt;
	logic [7:0] ptr, next_ptr, tx, next_tx;
	logic drive, next_drive, seen_tog, next_seen_tog;
	logic wr_tog, next_wr_tog, req_tog, next_req_tog;
	rtccfg_pkg::rtccfg_wr_t wr_word, next_wr_word;
	logic [7:0] rd_data;
	logic ack_tog;

	// Start is sda falling while scl high
	assign next_start_tog = scl_in ? ~start_tog : start_tog;

	always_ff @(negedge sda_in or posedge link_hold) begin
		if (link_hold)
			start_tog <= 1'b0;
		else
			start_tog <= next_start_tog;
	end

	always_ff @(posedge scl_in or posedge link_hold) begin
		if (link_hold) begin
			rx <= 8'h00;
			master_nack <= 1'b1;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			rx <= (bit_cnt < 4'h8) ? {rx[6:0], sda_in} : rx;
			master_nack <= (bit_cnt == 4'h8) ? sda_in : master_nack;
			ack_s1 <= ack_tog;
			ack_s2 <= ack_s1;
		end
	end

	always_comb begin
		next_lstate = lstate;
		next_bit_cnt = bit_cnt;
		next_ptr = ptr;
		next_tx = tx;
		next_drive = drive;
		next_seen_tog = seen_tog;
		next_wr_tog = wr_tog;
		next_req_tog = req_tog;
		next_wr_word = wr_word;
		// Marker set one START hold time before this edge
		if (start_tog != seen_tog) begin
			next_seen_tog = start_tog;
			next_lstate = L_ADDR;
			next_bit_cnt = 4'h0;
			next_drive = 1'b0;
		end else if (lstate == L_IDLE) begin
			next_drive = 1'b0;
		end else if (bit_cnt == 4'h7) begin
			next_bit_cnt = 4'h8;
			next_drive = 1'b1;
			case (lstate)
			L_ADDR: begin
				if (rx[7:1] != DEV_ADDR) begin
					next_lstate = L_IDLE;
					next_drive = 1'b0;
				end else if (rx[0]) begin
					next_lstate = L_READ;
				end else begin
					next_lstate = L_REG;
				end
			end
			L_REG: begin
				next_ptr = rx;
				next_req_tog = ~req_tog;
				next_lstate = L_WRITE;
			end
			L_WRITE: begin
				next_wr_word = '{addr: ptr, data: rx};
				next_wr_tog = ~wr_tog;
				next_ptr = ptr + 8'h01;
				next_req_tog = ~req_tog;
			end
			default: next_drive = 1'b0;
			endcase
		end else if (bit_cnt == 4'h8) begin
			next_bit_cnt = 4'h0;
			next_drive = 1'b0;
			if (lstate == L_READ) begin
				if (master_nack) begin
					next_lstate = L_IDLE;
				end else begin
					// Prefetch not back yet reads as all ones
					next_tx = (ack_s2 == req_tog) ? rd_data : 8'hFF;
					next_drive = ~next_tx[7];
					next_ptr = ptr + 8'h01;
					next_req_tog = ~req_tog;
				end
			end
		end else begin
			next_bit_cnt = bit_cnt + 4'h1;
			if (lstate == L_READ) begin
				next_tx = {tx[6:0], 1'b1};
				next_drive = ~next_tx[7];
			end
		end
	end

	always_ff @(negedge scl_in or posedge link_hold) begin
		if (link_hold) begin
			lstate <= L_IDLE;
			bit_cnt <= 4'h0;
			ptr <= 8'h00;
			tx <= 8'hFF;
			drive <= 1'b0;
			sda_drive_n <= 1'b1;
			seen_tog <= 1'b0;
			wr_tog <= 1'b0;
			req_tog <= 1'b0;
			wr_word <= '0;
		end else begin
			lstate <= next_lstate;
			bit_cnt <= next_bit_cnt;
			ptr <= next_ptr;
			tx <= next_tx;
			drive <= next_drive;
			sda_drive_n <= ~next_drive;
			seen_tog <= next_seen_tog;
			wr_tog <= next_wr_tog;
			req_tog <= next_req_tog;
			wr_word <= next_wr_word;
		end
	end

	assign sda_out = 1'b0;

	////////////////////////////////////////////////////////////////////////
	// System domain: registers, counting chain, pins
	logic [7:0] regs [0:rtccfg_pkg::NREG-1];
	logic [7:0] next_regs [0:rtccfg_pkg::NREG-1];
	logic [7:0] chain [0:6];
	logic [7:0] next_chain [0:6];
	logic [1:0] sync_delay, next_sync_delay;
	logic [2:0] wr_s, rq_s, ref_s;
	logic rd_pend, next_rd_pend, next_ack_tog;
	logic [7:0] next_rd_data;
	logic load_prev;
	logic [24:0] prescale, next_prescale;
	logic [15:0] ref_cnt, next_ref_cnt;
	logic [23:0] sqw_cnt, next_sqw_cnt;
	logic sqw, next_sqw;
	logic next_first_out, next_first_drive_n;
	logic next_second_out, next_second_drive_n;
	logic next_a1_match, next_a2_match;

	always_comb begin
		logic [7:0] c1, c2, rd_a, mon, date_last;
		logic run, tick, wr_edge, rq_edge, irq_all;
		logic [15:0] ref_div;
		c1 = regs[0];
		c2 = regs[1];
		rd_a = ptr;
		mon = 8'h00;
		date_last = 8'h31;
		run = 1'b0;
		tick = 1'b0;
		wr_edge = 1'b0;
		rq_edge = 1'b0;
		irq_all = 1'b0;
		ref_div = rtccfg_pkg::REF_DIV_0;
		for (int i = 0; i < rtccfg_pkg::NREG; i++)
			next_regs[i] = regs[i];
		for (int i = 0; i < 7; i++)
			next_chain[i] = chain[i];
		next_sync_delay = sync_delay;
		next_rd_data = rd_data;
		next_ack_tog = ack_tog;
		wr_edge = wr_s[1] ^ wr_s[2];
		rq_edge = rq_s[1] ^ rq_s[2];
		next_rd_pend = rq_edge;
		if (wr_edge) begin
			if (wr_word.addr == rtccfg_pkg::ADDR_SYNC)
				next_sync_delay = wr_word.data[1:0];
			else if (wr_word.addr <= rtccfg_pkg::ADDR_TMR_INIT)
				next_regs[wr_word.addr[4:0]] =
					wr_word.data & wr_mask(wr_word.addr);
		end
		// Answer one cycle late so a same-edge write is seen
		if (rd_pend) begin
			next_ack_tog = ~ack_tog;
			if (rd_a == rtccfg_pkg::ADDR_SYNC)
				next_rd_data = {6'h00, sync_delay};
			else if (rd_a == rtccfg_pkg::ADDR_TMR_CNT)
				next_rd_data = timer_count_value;
			else if (rd_a > rtccfg_pkg::ADDR_TMR_INIT)
				next_rd_data = 8'h00;
			else if (rd_a >= rtccfg_pkg::ADDR_SEC
				&& rd_a <= rtccfg_pkg::ADDR_YEAR
				&& c2[rtccfg_pkg::CFG2_RD_RUN])
				next_rd_data = chain[3'(rd_a - rtccfg_pkg::ADDR_SEC)];
			else
				next_rd_data = regs[rd_a[4:0]];
		end
		run = !c1[rtccfg_pkg::CFG1_OSC_DIS] && !c2[rtccfg_pkg::CFG2_RETEN]
			&& !c1[rtccfg_pkg::CFG1_SOFT_RST];
		case (c1[rtccfg_pkg::CFG1_REF_SEL +: 2])
		2'h0: ref_div = rtccfg_pkg::REF_DIV_0;
		2'h1: ref_div = rtccfg_pkg::REF_DIV_1;
		2'h2: ref_div = rtccfg_pkg::REF_DIV_2;
		default: ref_div = rtccfg_pkg::REF_DIV_3;
		endcase
		next_prescale = prescale;
		next_ref_cnt = ref_cnt;
		tick = 1'b0;
		if (!run) begin
			next_prescale = 25'h0000000;
			next_ref_cnt = 16'h0000;
		end else if (c1[rtccfg_pkg::CFG1_EXT_REF]) begin
			if (ref_s[1] && !ref_s[2]) begin
				tick = (ref_cnt == ref_div - 16'h0001);
				next_ref_cnt = tick ? 16'h0000 : ref_cnt + 16'h0001;
			end
		end else begin
			tick = (prescale == 25'(SEC_CYCLES - 1));
			next_prescale = tick ? 25'h0000000 : prescale + 25'h0000001;
		end
		mon = {3'h0, chain[5][4:0]};
		if (mon == 8'h02)
			date_last = ((!chain[6][4] && chain[6][1:0] == 2'h0
				&& !chain[6][2] || !chain[6][4] && chain[6][3:0] == 4'h4)
				|| (chain[6][4] && (chain[6][3:0] == 4'h2
				|| chain[6][3:0] == 4'h6))) ? 8'h29 : 8'h28;
		else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09
			|| mon == 8'h11)
			date_last = 8'h30;
		if (c2[rtccfg_pkg::CFG2_LOAD] && !load_prev) begin
			for (int i = 0; i < 7; i++)
				next_chain[i] = regs[3'(i) + 5'h06];
		end else if (tick) begin
			next_chain[0] = bcd_next(chain[0], rtccfg_pkg::BCD_MS_LAST, 8'h00);
			if (chain[0] == rtccfg_pkg::BCD_MS_LAST) begin
				next_chain[1] = bcd_next(chain[1], rtccfg_pkg::BCD_MS_LAST,
					8'h00);
				if (chain[1] == rtccfg_pkg::BCD_MS_LAST) begin
					next_chain[2] = bcd_next(chain[2],
						rtccfg_pkg::BCD_HR_LAST, 8'h00);
					if (chain[2] == rtccfg_pkg::BCD_HR_LAST) begin
						next_chain[3] = bcd_next(chain[3],
							rtccfg_pkg::BCD_DAY_LAST, 8'h01);
						next_chain[4] = bcd_next(chain[4], date_last, 8'h01);
						if (chain[4] == date_last) begin
							mon = bcd_next(mon, rtccfg_pkg::BCD_MON_LAST, 8'h01);
							next_chain[5] = {chain[5][7], 2'h0, mon[4:0]};
							if (chain[5][4:0] == rtccfg_pkg::BCD_MON_LAST[4:0]) begin
								next_chain[6] = bcd_next(chain[6],
									rtccfg_pkg::BCD_YEAR_LAST, 8'h00);
								next_chain[5][7] = chain[5][7]
									^ (chain[6] == rtccfg_pkg::BCD_YEAR_LAST);
							end
						end
					end
				end
			end
		end
		case (c1[rtccfg_pkg::CFG1_SQW_SEL +: 2])
		2'h0: next_sqw_cnt = 24'(SQW_SLOW_HALF - 1);
		2'h1: next_sqw_cnt = 24'(rtccfg_pkg::SQW_HALF_1 - 1);
		2'h2: next_sqw_cnt = 24'(rtccfg_pkg::SQW_HALF_2 - 1);
		default: next_sqw_cnt = 24'(rtccfg_pkg::SQW_HALF_3 - 1);
		endcase
		next_sqw = sqw;
		if (!run)
			next_sqw = 1'b0;
		else if (sqw_cnt == 24'h000000)
			next_sqw = ~sqw;
		else
			next_sqw_cnt = sqw_cnt - 24'h000001;
		irq_all = alarm_one_event || alarm_two_event || timer_event;
		next_first_out = 1'b0;
		next_second_out = 1'b0;
		next_second_drive_n = 1'b0;
		next_first_drive_n = 1'b1;
		case ({c1[rtccfg_pkg::CFG1_PIN_FN], c1[rtccfg_pkg::CFG1_EXT_REF]})
		2'b00: begin
			next_first_drive_n = !irq_all;
			next_second_out = sqw;
		end
		2'b01: next_second_out = sqw;
		2'b10: begin
			next_first_drive_n = !(alarm_one_event || timer_event);
			next_second_drive_n = !alarm_two_event;
		end
		default: next_second_drive_n = !irq_all;
		endcase
		next_a1_match = (regs[13][7] || regs[13][6:0] == chain[0][6:0])
			&& (regs[14][7] || regs[14][6:0] == chain[1][6:0])
			&& (regs[15][7] || regs[15][5:0] == chain[2][5:0])
			&& (regs[16][7] || (regs[16][6] ? regs[16][3:0] == chain[3][3:0]
				: regs[16][5:0] == chain[4][5:0]))
			&& (regs[17][7] || regs[17][4:0] == chain[5][4:0])
			&& (regs[17][6] || regs[18] == chain[6]);
		next_a2_match = chain[0] == 8'h00
			&& (regs[19][7] || regs[19][6:0] == chain[1][6:0])
			&& (regs[20][7] || regs[20][5:0] == chain[2][5:0])
			&& (regs[21][7] || (regs[21][6] ? regs[21][3:0] == chain[3][3:0]
				: regs[21][5:0] == chain[4][5:0]));
	end

	always_ff @(posedge clk_sys) begin
		link_hold <= !rst_n;
		wr_s <= {wr_s[1:0], wr_tog};
		rq_s <= {rq_s[1:0], req_tog};
		ref_s <= {ref_s[1:0], first_pin_in};
		if (!rst_n) begin
			for (int i = 0; i < rtccfg_pkg::NREG; i++)
				regs[i] <= 8'h00;
			regs[0] <= rtccfg_pkg::CFG1_RST;
			regs[1] <= rtccfg_pkg::CFG2_RST;
			for (int i = 0; i < 7; i++)
				chain[i] <= 8'h00;
			sync_delay <= 2'h0;
			rd_pend <= 1'b0;
			rd_data <= 8'hFF;
			ack_tog <= 1'b0;
			load_prev <= 1'b0;
			prescale <= 25'h0000000;
			ref_cnt <= 16'h0000;
			sqw_cnt <= 24'h000000;
			sqw <= 1'b0;
			first_pin_out <= 1'b0;
			first_pin_drive_n <= 1'b1;
			second_pin_out <= 1'b0;
			second_pin_drive_n <= 1'b1;
			oscillator_run <= 1'b0;
			retention_mode <= 1'b0;
			bus_timeout_enable <= 1'b1;
			alarm_one_match <= 1'b0;
			alarm_two_match <= 1'b0;
		end else begin
			regs <= next_regs;
			chain <= next_chain;
			sync_delay <= next_sync_delay;
			rd_pend <= next_rd_pend;
			rd_data <= next_rd_data;
			ack_tog <= next_ack_tog;
			load_prev <= regs[1][rtccfg_pkg::CFG2_LOAD];
			prescale <= next_prescale;
			ref_cnt <= next_ref_cnt;
			sqw_cnt <= next_sqw_cnt;
			sqw <= next_sqw;
			first_pin_out <= next_first_out;
			first_pin_drive_n <= next_first_drive_n;
			second_pin_out <= next_second_out;
			second_pin_drive_n <= next_second_drive_n;
			oscillator_run <= !regs[0][rtccfg_pkg::CFG1_OSC_DIS]
				&& !regs[1][rtccfg_pkg::CFG2_RETEN];
			retention_mode <= regs[1][rtccfg_pkg::CFG2_RETEN];
			bus_timeout_enable <= regs[1][rtccfg_pkg::CFG2_TMO_EN];
			alarm_one_match <= next_a1_match;
			alarm_two_match <= next_a2_match;
		end
	end

endmodule

// ===== dv/rtccfg_sva.sv
`timescale 1ns/10ps
module rtccfg_sva (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Serial data
	input wire logic sda_out,
	input wire logic sda_drive_n,
	// Shared pins
	input wire logic first_pin_out,
	input wire logic first_pin_drive_n,
	input wire logic second_pin_out,
	input wire logic second_pin_drive_n,
	// Status
	input wire logic oscillator_run,
	input wire logic retention_mode,
	input wire logic bus_timeout_enable
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	a_reset_vals: assert property (
		$rose(rst_n) |-> bus_timeout_enable && !oscillator_run &&
			!retention_mode && sda_drive_n && first_pin_drive_n)
		else $error("outputs wrong at reset release");
	a_route_start: assert property (
		$rose(rst_n) |=> !second_pin_drive_n && !second_pin_out)
		else $error("second pin not clock output after reset");
	a_open_drain: assert property (
		!sda_out && !first_pin_out)
		else $error("open drain line driven high");
	a_wave_drive: assert property (
		second_pin_out |-> !second_pin_drive_n)
		else $error("square wave high while pin not driven");
	a_wave_half: assert property (
		$fell(second_pin_out) |=> !second_pin_out [*8])
		else $error("square wave low half too short");
	a_osc_stop: assert property (
		!oscillator_run [*3] |=> !second_pin_out)
		else $error("square wave runs with oscillator off");
	a_reten_wave: assert property (
		retention_mode [*3] |=> !second_pin_out)
		else $error("square wave runs in retention");
	a_osc_steady: assert property (
		$changed(oscillator_run) |=> $stable(oscillator_run) [*8])
		else $error("oscillator state flickers");
	a_sda_release: assert property (
		$fell(sda_drive_n) |-> ##[1:40] sda_drive_n)
		else $error("data line held low too long");
endmodule

// ===== dv/rtccfg_host.sv
`timescale 1ns/10ps
module rtccfg_host #(
	parameter logic [6:0] DEV_ADDR = 7'h2A
) (
	// Serial bus
	output logic scl,
	output logic sda_lo,
	input wire logic sda
);
	logic [7:0] nak_cnt;

	initial begin
		scl = 1'b1;
		sda_lo = 1'b0;
		nak_cnt = 8'h00;
	end

	// Data changes only while the clock is low
	task automatic clk_bit(input logic b, output logic r);
		sda_lo = !b;
		#20 scl = 1'b1;
		#20 r = sda;
		#20 scl = 1'b0;
		#20;
	endtask

	task automatic start();
		sda_lo = 1'b0;
		#20 scl = 1'b1;
		#20 sda_lo = 1'b1;
		#20 scl = 1'b0;
		#20;
	endtask

	task automatic stop();
		sda_lo = 1'b1;
		#20 scl = 1'b1;
		#20 sda_lo = 1'b0;
		#40;
	endtask

	task automatic put_byte(input logic [7:0] v);
		logic r;
		for (int i = 7; i >= 0; i--) clk_bit(v[i], r);
		clk_bit(1'b1, r);
		if (r) nak_cnt++;
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		start();
		put_byte({DEV_ADDR, 1'b0});
		put_byte(a);
		put_byte(d);
		stop();
	endtask

	// Gap lets the device prefetch the first byte
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic r;
		start();
		put_byte({DEV_ADDR, 1'b0});
		put_byte(a);
		#1200;
		start();
		put_byte({DEV_ADDR, 1'b1});
		for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
		clk_bit(1'b1, r);
		stop();
	endtask
endmodule

// ===== dv/tb_rtc_config_control_regs.sv
`timescale 1ns/10ps
module tb_rtc_config_control_regs;
	logic clk_sys, rst_n, scl, host_lo, sda;
	logic first_pin_in, alarm_one_event, alarm_two_event, timer_event;
	logic [7:0] timer_count_value, rv;
	logic sda_out, sda_drive_n, first_pin_out, first_pin_drive_n;
	logic second_pin_out, second_pin_drive_n, oscillator_run;
	logic retention_mode, bus_timeout_enable;
	logic alarm_one_match, alarm_two_match;
	int err_total, checked;

	// Pulled-up data wire
	assign sda = !(host_lo || !sda_drive_n);

	rtccfg_top #(.SEC_CYCLES(20), .SQW_SLOW_HALF(10)) dut (
		.clk_sys, .rst_n, .scl_in(scl), .sda_in(sda), .sda_out,
		.sda_drive_n, .first_pin_in, .first_pin_out, .first_pin_drive_n,
		.second_pin_out, .second_pin_drive_n, .alarm_one_event,
		.alarm_two_event, .timer_event, .timer_count_value,
		.oscillator_run, .retention_mode, .bus_timeout_enable,
		.alarm_one_match, .alarm_two_match
	);
	rtccfg_host host (.scl(scl), .sda_lo(host_lo), .sda(sda));

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		host.wr(a, d);
		repeat (8) @(posedge clk_sys);
		#1;
	endtask

	task automatic give_verdict();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	task automatic t_power_on();
		chk({6'h00, bus_timeout_enable, oscillator_run}, 8'h02);
		host.rd(rtccfg_pkg::ADDR_CFG1, rv);
		chk(rv, 8'h0E);
		host.rd(rtccfg_pkg::ADDR_CFG2, rv);
		chk(rv, 8'h0C);
	endtask

	task automatic t_retention();
		wr(8'h01, 8'hF7);
		wr(8'h00, 8'h08);
		host.rd(8'h01, rv);
		chk(rv, 8'h46);
		chk({retention_mode, bus_timeout_enable, oscillator_run}, 8'h04);
		wr(8'h01, 8'h0C);
		wr(8'h00, 8'h00);
		chk({retention_mode, bus_timeout_enable, oscillator_run}, 8'h03);
	endtask

	task automatic t_wave();
		logic [7:0] n;
		n = 8'h00;
		while (second_pin_out !== 1'b1 && n < 8'h28) begin
			@(negedge clk_sys);
			n++;
		end
		n = 8'h00;
		while (second_pin_out === 1'b1 && n < 8'h28) begin
			@(negedge clk_sys);
			n++;
		end
		chk(n, 8'h0A);
		wr(8'h00, 8'h01);
		n = 8'h00;
		repeat (30) begin
			@(negedge clk_sys);
			n = n + {7'h00, second_pin_out};
		end
		chk(n, 8'h00);
	endtask

	task automatic t_time();
		wr(8'h01, 8'h08);
		wr(8'h06, 8'h58);
		wr(8'h07, 8'h12);
		host.rd(8'h07, rv);
		chk(rv, 8'h12);
		wr(8'h01, 8'h0A);
		wr(8'h01, 8'h0C);
		host.rd(8'h06, rv);
		chk(rv, 8'h58);
		wr(8'h00, 8'h00);
		// Three seconds pass, enough to roll into the next minute
		repeat (60) @(posedge clk_sys);
		host.rd(8'h07, rv);
		chk(rv, 8'h13);
		wr(8'h01, 8'h08);
		host.rd(8'h07, rv);
		chk(rv, 8'h12);
		wr(8'h01, 8'h0C);
	endtask

	task automatic t_misc();
		wr(8'h03, 8'hFF);
		host.rd(8'h03, rv);
		chk(rv, 8'h00);
		host.rd(8'h16, rv);
		chk(rv, 8'hA5);
		wr(8'h58, 8'hFF);
		host.rd(8'h58, rv);
		chk(rv, 8'h03);
		wr(8'h10, 8'hD5);
		host.rd(8'h10, rv);
		chk(rv, 8'hD5);
	endtask

	task automatic t_routing();
		logic [7:0] mode [4] = '{8'h01, 8'h81, 8'h41, 8'hC1};
		logic [7:0] exp [4] = '{8'h80, 8'hAA, 8'hD9, 8'hEA};
		logic [7:0] got;
		for (int m = 0; m < 4; m++) begin
			wr(8'h00, mode[m]);
			got = {first_pin_drive_n, second_pin_drive_n, 6'h00};
			@(posedge clk_sys);
			alarm_one_event <= 1'b1;
			repeat (8) @(posedge clk_sys);
			#1 got[5:4] = {first_pin_drive_n, second_pin_drive_n};
			@(posedge clk_sys);
			alarm_one_event <= 1'b0;
			alarm_two_event <= 1'b1;
			repeat (8) @(posedge clk_sys);
			#1 got[3:2] = {first_pin_drive_n, second_pin_drive_n};
			@(posedge clk_sys);
			alarm_two_event <= 1'b0;
			timer_event <= 1'b1;
			repeat (8) @(posedge clk_sys);
			#1 got[1:0] = {first_pin_drive_n, second_pin_drive_n};
			@(posedge clk_sys);
			timer_event <= 1'b0;
			repeat (8) @(posedge clk_sys);
			chk(got, exp[m]);
		end
	endtask

	task automatic t_reference();
		wr(8'h00, 8'h90);
		wr(8'h06, 8'h59);
		wr(8'h01, 8'h0E);
		wr(8'h01, 8'h0C);
		wr(8'h0D, 8'h59);
		wr(8'h0E, 8'h80);
		wr(8'h13, 8'h80);
		chk({6'h00, alarm_one_match, alarm_two_match}, 8'h02);
		repeat (50) begin
			@(posedge clk_sys);
			first_pin_in <= 1'b1;
			repeat (2) @(posedge clk_sys);
			first_pin_in <= 1'b0;
			repeat (2) @(posedge clk_sys);
		end
		repeat (4) @(posedge clk_sys);
		#1;
		chk({6'h00, alarm_one_match, alarm_two_match}, 8'h01);
		host.rd(8'h07, rv);
		chk(rv, 8'h13);
	endtask

	////////////////////////////////////////////////////////////////////////
	initial begin
		err_total = 0;
		checked = 0;
		rst_n = 1'b0;
		first_pin_in = 1'b0;
		alarm_one_event = 1'b0;
		alarm_two_event = 1'b0;
		timer_event = 1'b0;
		timer_count_value = 8'hA5;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		#1;
		t_power_on();
		t_retention();
		t_wave();
		t_time();
		t_misc();
		t_routing();
		t_reference();
		chk(host.nak_cnt, 8'h00);
		give_verdict();
	end

	initial begin
		#1000000;
		err_total++;
		give_verdict();
	end
endmodule

bind rtccfg_top rtccfg_sva u_sva (
	.clk_sys, .rst_n, .sda_out, .sda_drive_n, .first_pin_out,
	.first_pin_drive_n, .second_pin_out, .second_pin_drive_n,
	.oscillator_run, .retention_mode, .bus_timeout_enable
);
